/* hdl/sep_device.sv */
// Operation
// - supervoltage on frame pin enters programming mode
// - programmer lowers frame to 5V before shifting
// - command words travel bit 31 first
// - previous response shifts out while command shifts in
// - first response after entry is indeterminate
// - after 32 bits: frame 0V, two pulses
// - read: frame back to 5V before next
// - during write response pin means ready
// - ready low by second 0V-phase rising edge
// - write-done flag set when write completes
// - programmer waits write-done before raising frame
// - power loss leaves programming mode
// - bit 29 selects data eeprom; reserved bits zero
// - bit 28 selects code eeprom/init space
// - bit 24: 1 read, 0 write
// - bits 18..8 hold the byte address
// - bits 7..0 hold write data, zero on read
// - response bits 7..0 return the byte
// - response bits 18..8 echo the address
// - multi-byte read: sequence addresses, check echoes
// - programming addresses map as in normal operation
// - auxiliary pin open or high while programming
`timescale 1ns/100ps
`default_nettype none
module sep_device #(
  parameter int DATA_DEPTH = sep_pkg::DATA_DEPTH,
  parameter int CODE_DEPTH = sep_pkg::CODE_DEPTH,
  parameter int WRITE_CYC  = sep_pkg::T_WRITE_CYC
) (
  input  wire logic                         clk,          // 200 MHz core clock
  input  wire logic                         reset_n,      // async reset, active low
  sep_if.device                             link,         // four-wire programming port
  input  wire logic                         power_good,   // low while supply is removed
  input  wire logic                         norm_code,    // normal-mode read: 1 code, 0 data
  input  wire logic [sep_pkg::ADDR_W-1:0]   norm_addr,    // normal-mode read address
  output logic      [sep_pkg::BYTE_W-1:0]   norm_rdata,   // normal-mode read data, one cycle late
  output logic                              prog_mode,    // device is in programming mode
  output logic                              write_done    // status flag: last write completed
);
  localparam int DA_W  = $clog2(DATA_DEPTH);
  localparam int CA_W  = $clog2(CODE_DEPTH);
  localparam int WC_W  = $clog2(WRITE_CYC + 1);

  typedef enum logic [4:0] {
    D_IDLE  = 5'h01,
    D_ENTRY = 5'h02,
    D_SHIFT = 5'h04,
    D_EXEC  = 5'h08,
    D_WAIT5 = 5'h10
  } sep_dstate_t;

  typedef struct packed {
    logic                clk_s1;
    logic                clk_s2;
    logic                clk_d;
    sep_pkg::sep_frame_t frm_s1;
    sep_pkg::sep_frame_t frm_s2;
    logic                cmd_s1;
    logic                cmd_s2;
    sep_dstate_t         state;
    logic [5:0]          bit_cnt;
    logic [1:0]          pulse;
    logic [31:0]         cmd_sr;
    logic [31:0]         resp_sr;
    logic                out_bit;
    logic                rdy_mode;
    logic                busy;
    logic [WC_W-1:0]     wcnt;
    logic                done;
    logic                we;
    logic                we_code;
    logic [sep_pkg::ADDR_W-1:0] waddr;
    logic [sep_pkg::BYTE_W-1:0] wdata;
    logic [sep_pkg::BYTE_W-1:0] nrd;
  } sep_dev_t;

  sep_dev_t r;
  sep_dev_t next_r;

  logic [sep_pkg::BYTE_W-1:0] data_mem [DATA_DEPTH];
  logic [sep_pkg::BYTE_W-1:0] code_mem [CODE_DEPTH];

  logic                       rise;
  logic [sep_pkg::ADDR_W-1:0] c_addr;
  logic [sep_pkg::BYTE_W-1:0] c_byte;
  logic                       c_dsel;
  logic                       c_csel;
  logic [sep_pkg::BYTE_W-1:0] rd_byte;

  // serial clock rising edge and command fields of the word just shifted in
  assign rise   = r.clk_s2 & ~r.clk_d;
  assign c_addr = r.cmd_sr[sep_pkg::CMD_ADDR_MSB:sep_pkg::CMD_ADDR_LSB];
  assign c_byte = r.cmd_sr[sep_pkg::CMD_DATA_MSB:0];
  assign c_dsel = r.cmd_sr[sep_pkg::CMD_DATA_SEL];
  assign c_csel = r.cmd_sr[sep_pkg::CMD_CODE_SEL];

  // same indexing as normal-mode reads, so both views agree
  always_comb begin
    if (c_dsel) begin
      rd_byte = data_mem[c_addr[DA_W-1:0]];
    end else if (c_csel) begin
      rd_byte = code_mem[c_addr[CA_W-1:0]];
    end else begin
      rd_byte = '0;
    end
  end

  // link sequencing; pin inputs pass two flops before any use
  always_comb begin
    next_r         = r;
    next_r.clk_s1  = link.programming_clock_port_line;
    next_r.clk_s2  = r.clk_s1;
    next_r.clk_d   = r.clk_s2;
    next_r.frm_s1  = link.frame_pin_port_line;
    next_r.frm_s2  = r.frm_s1;
    next_r.cmd_s1  = link.command_input_port_line;
    next_r.cmd_s2  = r.cmd_s1;
    next_r.we      = 1'b0;
    next_r.nrd     = norm_code ? code_mem[norm_addr[CA_W-1:0]]
                               : data_mem[norm_addr[DA_W-1:0]];

    // write timer runs regardless of link state
    if (r.busy) begin
      if (r.wcnt == '0) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        if (r.rdy_mode) begin
          next_r.out_bit = 1'b1;
        end
      end else begin
        next_r.wcnt = r.wcnt - 1'b1;
      end
    end

    unique case (r.state)
      D_IDLE: begin
        if (r.frm_s2 == sep_pkg::FRAME_SV) begin
          next_r.state = D_ENTRY;
        end
      end
      D_ENTRY: begin
        // response register is not cleared: the first word out is junk
        if (r.frm_s2 == sep_pkg::FRAME_5V) begin
          next_r.state   = D_SHIFT;
          next_r.bit_cnt = '0;
        end
      end
      D_SHIFT: begin
        if (rise) begin
          next_r.cmd_sr   = {r.cmd_sr[30:0], r.cmd_s2};
          next_r.out_bit  = r.resp_sr[31];
          next_r.resp_sr  = {r.resp_sr[30:0], 1'b0};
          next_r.bit_cnt  = r.bit_cnt + 1'b1;
          next_r.rdy_mode = 1'b0;
        end
        if (r.frm_s2 == sep_pkg::FRAME_0V) begin
          // a short or long word is not executed
          next_r.state = (r.bit_cnt == 6'(sep_pkg::WORD_W)) ? D_EXEC : D_WAIT5;
          next_r.pulse = '0;
        end
      end
      D_EXEC: begin
        if (rise) begin
          next_r.pulse = r.pulse + 1'b1;
          if (r.pulse == '0) begin
            if (r.cmd_sr[sep_pkg::CMD_READ]) begin
              next_r.resp_sr = {{sep_pkg::RESP_PAD_W{1'b0}}, c_addr, rd_byte};
            end else begin
              next_r.resp_sr  = {{sep_pkg::RESP_PAD_W{1'b0}}, c_addr, c_byte};
              next_r.rdy_mode = 1'b1;
              next_r.out_bit  = 1'b0;
              next_r.done     = 1'b0;
              next_r.busy     = 1'b1;
              next_r.wcnt     = WC_W'(WRITE_CYC - 1);
              next_r.we       = c_dsel | c_csel;
              next_r.we_code  = ~c_dsel;
              next_r.waddr    = c_addr;
              next_r.wdata    = c_byte;
            end
          end
          if (r.pulse == 2'(sep_pkg::EXEC_PULSES - 1)) begin
            next_r.state = D_WAIT5;
          end
        end
        if (r.frm_s2 == sep_pkg::FRAME_5V) begin
          next_r.state   = D_SHIFT;
          next_r.bit_cnt = '0;
        end
      end
      D_WAIT5: begin
        // the programmer raises the frame after ready on a write, right after the two pulses on a read
        if (r.frm_s2 == sep_pkg::FRAME_5V) begin
          next_r.state   = D_SHIFT;
          next_r.bit_cnt = '0;
        end
      end
      default: begin
        next_r.state = D_IDLE;
      end
    endcase

    // supervoltage re-entry restarts framing
    if (r.state != D_IDLE && r.frm_s2 == sep_pkg::FRAME_SV) begin
      next_r.state = D_ENTRY;
    end
    if (!power_good) begin
      next_r.state = D_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r       <= '0;
      r.state <= D_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // memory arrays kept out of the state word; written one cycle after the decision
  always_ff @(posedge clk) begin
    if (r.we && r.we_code) begin
      code_mem[r.waddr[CA_W-1:0]] <= r.wdata;
    end
    if (r.we && !r.we_code) begin
      data_mem[r.waddr[DA_W-1:0]] <= r.wdata;
    end
  end

  assign link.response_output_port_line = r.out_bit;
  assign norm_rdata = r.nrd;
  assign prog_mode  = (r.state != D_IDLE);
  assign write_done = r.done;
endmodule
`default_nettype wire

/* hdl/sep_pkg.sv */
`default_nettype none
package sep_pkg;
  // command and response word layout
  localparam int WORD_W       = 32;
  localparam int ADDR_W       = 11;
  localparam int BYTE_W       = 8;
  localparam int CMD_DATA_SEL = 29;  // data eeprom space
  localparam int CMD_CODE_SEL = 28;  // code eeprom / init register space
  localparam int CMD_READ     = 24;  // 1 read, 0 write
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_ADDR_MSB = 18;
  localparam int CMD_DATA_MSB = 7;
  localparam int RESP_PAD_W   = 13;  // don't-care bits 31..19, driven zero
  localparam int EXEC_PULSES  = 2;   // clock pulses in the 0V completion phase

  // frame pin level, an analog pin carried as a code
  typedef logic [1:0] sep_frame_t;
  localparam sep_frame_t FRAME_0V = 2'h0;
  localparam sep_frame_t FRAME_5V = 2'h1;
  localparam sep_frame_t FRAME_SV = 2'h2;

  // memory sizes
  localparam int DATA_DEPTH = 64;
  localparam int CODE_DEPTH = 2048;

  // timing at 200 MHz
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_ACCESS_NS   = 850;
  localparam int T_ACCESS_CYC  = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_ENTRY_NS    = 1000;
  localparam int T_ENTRY_CYC   = (T_ENTRY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_WRITE_NS    = 5000;
  localparam int T_WRITE_CYC   = (T_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // programmer register map (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_RESP   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_GO    = 0;
  localparam int CTRL_ENTER = 1;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_MODE  = 1;
  localparam int STAT_VALID = 2;
endpackage
`default_nettype wire

/* hdl/sep_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface sep_if;
  logic                programming_clock_port_line;  // serial clock from programmer
  sep_pkg::sep_frame_t frame_pin_port_line;          // 0V / 5V / supervoltage
  logic                command_input_port_line;      // command bits, msb first
  logic                response_output_port_line;    // response bits or ready
  logic                auxiliary_port_pin;           // held high while programming

  modport device (
    input  programming_clock_port_line,
    input  frame_pin_port_line,
    input  command_input_port_line,
    input  auxiliary_port_pin,
    output response_output_port_line
  );
  modport programmer (
    output programming_clock_port_line,
    output frame_pin_port_line,
    output command_input_port_line,
    output auxiliary_port_pin,
    input  response_output_port_line
  );
endinterface
`default_nettype wire

/* hdl/sep_programmer.sv */
`timescale 1ns/100ps
`default_nettype none
module sep_programmer #(
  parameter int HALF_CYC  = sep_pkg::T_ACCESS_CYC,  // serial clock half period
  parameter int ENTRY_CYC = sep_pkg::T_ENTRY_CYC    // supervoltage hold time
) (
  input  wire logic        clk,        // 200 MHz clock
  input  wire logic        reset_n,    // async reset, active low
  sep_if.programmer        link,       // four-wire programming port
  input  wire logic        hsel,       // ahb-lite slave select
  input  wire logic [31:0] haddr,      // ahb-lite address
  input  wire logic [1:0]  htrans,     // ahb-lite transfer type
  input  wire logic        hwrite,     // ahb-lite write
  input  wire logic [2:0]  hsize,      // ahb-lite size, word only
  input  wire logic [31:0] hwdata,     // ahb-lite write data
  input  wire logic        hready,     // ahb-lite bus ready
  output logic             hreadyout,  // always ready, no wait states
  output logic [31:0]      hrdata,     // ahb-lite read data
  output logic             hresp       // always okay
);
  typedef enum logic [7:0] {
    P_IDLE   = 8'h01,
    P_ENTER  = 8'h02,
    P_SETTLE = 8'h04,
    P_LOW    = 8'h08,
    P_HIGH   = 8'h10,
    P_EXEC   = 8'h20,
    P_READY  = 8'h40,
    P_RESUME = 8'h80
  } sep_pstate_t;

  typedef struct packed {
    sep_pstate_t         state;
    logic [15:0]         cnt;
    logic [5:0]          bit_cnt;
    logic [1:0]          pulse;
    logic [31:0]         tx;
    logic [31:0]         rx;
    logic [31:0]         cmd;
    logic [31:0]         resp;
    logic                is_read;
    logic                in_mode;
    logic                first;
    logic                valid;
    logic                pclk;
    logic                cbit;
    sep_pkg::sep_frame_t frame;
    logic                rs1;
    logic                rs2;
    logic                wpend;
    logic [7:0]          waddr;
    logic [31:0]         rdata;
  } sep_prg_t;

  sep_prg_t r;
  sep_prg_t next_r;

  logic       take;
  logic       go;
  logic       enter;
  logic [7:0] aoff;

  assign take  = hsel & htrans[1] & hready;
  assign aoff  = haddr[7:0];
  assign go    = r.wpend && r.waddr == sep_pkg::REG_CTRL && hwdata[sep_pkg::CTRL_GO];
  assign enter = r.wpend && r.waddr == sep_pkg::REG_CTRL && hwdata[sep_pkg::CTRL_ENTER];

  always_comb begin
    next_r       = r;
    next_r.rs1   = link.response_output_port_line;
    next_r.rs2   = r.rs1;
    next_r.wpend = take & hwrite;
    if (take) begin
      next_r.waddr = aoff;
    end

    // register reads answered in the next cycle from a flop
    if (take && !hwrite) begin
      unique case (aoff)
        sep_pkg::REG_CMD:    next_r.rdata = r.cmd;
        sep_pkg::REG_RESP:   next_r.rdata = r.resp;
        sep_pkg::REG_STATUS: next_r.rdata = {29'h0, r.valid, r.in_mode, r.state != P_IDLE};
        default:             next_r.rdata = 32'h0;
      endcase
    end
    if (r.wpend && r.waddr == sep_pkg::REG_CMD) begin
      next_r.cmd = hwdata;
    end

    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end

    unique case (r.state)
      P_IDLE: begin
        if (enter) begin
          next_r.frame = sep_pkg::FRAME_SV;
          next_r.cnt   = 16'(ENTRY_CYC - 1);
          next_r.state = P_ENTER;
        end else if (go && r.in_mode) begin
          next_r.tx      = r.cmd;
          next_r.cbit    = r.cmd[31];
          next_r.is_read = r.cmd[sep_pkg::CMD_READ];
          next_r.bit_cnt = '0;
          next_r.cnt     = 16'(HALF_CYC - 1);
          next_r.state   = P_LOW;
        end
      end
      P_ENTER: begin
        if (r.cnt == '0) begin
          next_r.frame   = sep_pkg::FRAME_5V;
          next_r.in_mode = 1'b1;
          next_r.first   = 1'b1;
          next_r.cnt     = 16'(HALF_CYC - 1);
          next_r.state   = P_SETTLE;
        end
      end
      P_SETTLE, P_RESUME: begin
        if (r.cnt == '0) begin
          next_r.state = P_IDLE;
        end
      end
      P_LOW: begin
        if (r.cnt == '0) begin
          next_r.pclk  = 1'b1;
          next_r.cnt   = 16'(HALF_CYC - 1);
          next_r.state = P_HIGH;
        end
      end
      P_HIGH: begin
        // sample a full access time after the rising edge
        if (r.cnt == '0) begin
          next_r.rx      = {r.rx[30:0], r.rs2};
          next_r.pclk    = 1'b0;
          next_r.bit_cnt = r.bit_cnt + 1'b1;
          next_r.tx      = {r.tx[30:0], 1'b0};
          next_r.cbit    = r.tx[30];
          next_r.cnt     = 16'(HALF_CYC - 1);
          if (r.bit_cnt == 6'(sep_pkg::WORD_W - 1)) begin
            next_r.frame = sep_pkg::FRAME_0V;
            next_r.pulse = '0;
            next_r.resp  = {r.rx[30:0], r.rs2};
            next_r.valid = ~r.first;
            next_r.first = 1'b0;
            next_r.state = P_EXEC;
          end else begin
            next_r.state = P_LOW;
          end
        end
      end
      P_EXEC: begin
        if (r.cnt == '0) begin
          next_r.cnt = 16'(HALF_CYC - 1);
          if (!r.pclk && r.pulse != 2'(sep_pkg::EXEC_PULSES)) begin
            next_r.pclk  = 1'b1;
            next_r.pulse = r.pulse + 1'b1;
          end else if (r.pclk) begin
            next_r.pclk = 1'b0;
          end else if (r.is_read) begin
            next_r.frame = sep_pkg::FRAME_5V;
            next_r.state = P_RESUME;
          end else begin
            next_r.state = P_READY;
          end
        end
      end
      P_READY: begin
        // ready was driven low during the pulses, so high here means done
        if (r.rs2) begin
          next_r.frame = sep_pkg::FRAME_5V;
          next_r.cnt   = 16'(HALF_CYC - 1);
          next_r.state = P_RESUME;
        end
      end
      default: begin
        next_r.state = P_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r       <= '0;
      r.state <= P_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign link.programming_clock_port_line = r.pclk;
  assign link.frame_pin_port_line         = r.frame;
  assign link.command_input_port_line     = r.cbit;
  assign link.auxiliary_port_pin          = 1'b1;   // held high while programming
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = r.rdata;
endmodule
`default_nettype wire

/* bench/sep_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module sep_properties (
  input wire logic                clk,                          // core clock
  input wire logic                reset_n,                      // async reset, active low
  input wire logic                programming_clock_port_line,  // serial clock
  input wire sep_pkg::sep_frame_t frame_pin_port_line,          // frame level code
  input wire logic                command_input_port_line,      // command bit
  input wire logic                response_output_port_line,    // response bit or ready
  input wire logic                auxiliary_port_pin,           // aux pin
  input wire logic                power_good,                   // supply present
  input wire logic                prog_mode,                    // device in mode
  input wire logic                write_done                    // write-done flag
);
  logic [5:0]  bits;    // rising serial edges seen in the 5V phase
  logic [1:0]  pulses;  // rising edges in the 0V phase, saturates at 3
  logic [31:0] word;    // command as seen on the wire
  logic        sclk_q;
  logic        rise;
  logic        f5;
  logic        f0;
  logic        fsv;

  // rising-edge detect of the serial clock and level decodes of the frame pin
  assign rise = programming_clock_port_line & ~sclk_q;
  assign f5   = (frame_pin_port_line == sep_pkg::FRAME_5V);
  assign f0   = (frame_pin_port_line == sep_pkg::FRAME_0V);
  assign fsv  = (frame_pin_port_line == sep_pkg::FRAME_SV);

  // shadow of the wire, so the properties know which command is executing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      bits   <= 6'h00;
      pulses <= 2'h0;
      word   <= 32'h0000_0000;
    end else begin
      sclk_q <= programming_clock_port_line;
      if (f5) begin
        pulses <= 2'h0;
        if (rise) begin
          bits <= bits + 6'h01;
          word <= {word[30:0], command_input_port_line};  // msb arrives first
        end
      end else begin
        bits <= 6'h00;
        if (rise && f0 && pulses != 2'h3) begin
          pulses <= pulses + 2'h1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_word_end;
    f0 && $past(f5);
  endsequence
  sequence s_second_pulse;
    rise && f0 && pulses == 2'h1 && !word[24];
  endsequence
  sequence s_write_end;
    f5 && $past(f0) && !word[24];
  endsequence
  sequence s_entry_end;
    !fsv && $past(fsv);
  endsequence

  a_aux_held_high: assert property (auxiliary_port_pin)
    else $error("aux pin not held high");
  a_cmd_moves_low: assert property ($changed(command_input_port_line) |-> !programming_clock_port_line)
    else $error("command bit changed while clock high");
  a_word_is_32: assert property (s_word_end |-> bits == 6'h20)
    else $error("frame dropped after wrong bit count");
  a_two_pulses_only: assert property (pulses != 2'h3)
    else $error("more than two execute pulses");
  a_ready_goes_low: assert property (s_second_pulse |-> ##[1:8] !response_output_port_line)
    else $error("ready not low after second pulse");
  a_done_before_next: assert property (s_write_end |-> write_done)
    else $error("frame raised before write done");
  a_mode_on_entry: assert property (s_entry_end |-> ##[0:16] prog_mode)
    else $error("no programming mode after entry");
  a_mode_lost_power: assert property (!power_good |-> ##[0:4] !prog_mode)
    else $error("mode kept without power");
  a_resp_bit_holds: assert property (f5 && bits != 6'h00 && !programming_clock_port_line
                                     && !$past(programming_clock_port_line) |-> $stable(response_output_port_line))
    else $error("response bit moved in clock-low half");
endmodule
`default_nettype wire

/* bench/serial_eeprom_programming_port_test.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_programming_port_test;
  localparam int SMALL       = 8;   // shortened divider and entry counts
  localparam int WRITE_SMALL = 64;  // write outlasts both execute pulses, so ready is still low there
  logic        clk;
  logic        reset_n;
  logic        power_good;
  logic        norm_code;
  logic [10:0] norm_addr;
  logic [7:0]  norm_rdata;
  logic        prog_mode;
  logic        write_done;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [31:0] rd;
  int          errors;
  int          checked;

  sep_if link ();
  sep_device #(.WRITE_CYC(WRITE_SMALL)) i_sep_device (
    .clk(clk), .reset_n(reset_n), .link(link), .power_good(power_good), .norm_code(norm_code),
    .norm_addr(norm_addr), .norm_rdata(norm_rdata), .prog_mode(prog_mode), .write_done(write_done));
  sep_programmer #(.HALF_CYC(SMALL), .ENTRY_CYC(SMALL)) i_sep_programmer (
    .clk(clk), .reset_n(reset_n), .link(link), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp));
  sep_properties i_sep_properties (
    .clk(clk), .reset_n(reset_n), .programming_clock_port_line(link.programming_clock_port_line),
    .frame_pin_port_line(link.frame_pin_port_line), .command_input_port_line(link.command_input_port_line),
    .response_output_port_line(link.response_output_port_line), .auxiliary_port_pin(link.auxiliary_port_pin),
    .power_good(power_good), .prog_mode(prog_mode), .write_done(write_done));

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // one ahb-lite single word transfer; read data taken at the data-phase edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask

  // one command word on the link, then the response it brought back
  task automatic send(input logic [31:0] cmd, output logic [31:0] resp);
    ahb(1'b1, sep_pkg::REG_CMD, cmd, rd);
    ahb(1'b1, sep_pkg::REG_CTRL, 32'h0000_0001, rd);
    repeat (2) @(posedge clk);
    do ahb(1'b0, sep_pkg::REG_STATUS, 32'h0000_0000, rd); while (rd[0] !== 1'b0);
    ahb(1'b0, sep_pkg::REG_RESP, 32'h0000_0000, resp);
    resp = resp & 32'h0007_FFFF;  // bits 31..19 carry nothing
  endtask

  task automatic t_reset();
    ahb(1'b0, sep_pkg::REG_STATUS, 32'h0000_0000, rd);
    chk_word(rd, 32'h0000_0000);
    chk_bit(prog_mode, 1'b0);
    chk_bit(link.auxiliary_port_pin, 1'b1);
  endtask

  // supervoltage entry, waits for the device itself to report the mode
  task automatic t_enter();
    ahb(1'b1, sep_pkg::REG_CTRL, 32'h0000_0002, rd);
    do ahb(1'b0, sep_pkg::REG_STATUS, 32'h0000_0000, rd); while (rd[0] !== 1'b0 || rd[1] !== 1'b1);
    for (int i = 0; i < 200 && prog_mode !== 1'b1; i++) @(posedge clk);
    chk_bit(prog_mode, 1'b1);
  endtask

  task automatic t_words();
    logic [31:0] r;
    send(32'h2000_05A5, r);
    ahb(1'b0, sep_pkg::REG_STATUS, 32'h0000_0000, rd);
    chk_bit(rd[2], 1'b0);
    chk_bit(write_done, 1'b1);
    send(32'h1007_FF3C, r);
    chk_word(r, 32'h0000_05A5);
    send(32'h2100_0500, r);
    chk_word(r, 32'h0007_FF3C);
    send(32'h1107_FF00, r);
    chk_word(r, 32'h0000_05A5);
    send(32'h0100_0500, r);
    chk_word(r, 32'h0007_FF3C);
    send(32'h2100_0500, r);
    chk_word(r, 32'h0000_0500);
  endtask

  // programmed bytes seen through the normal-mode read port
  task automatic t_normal();
    @(posedge clk);
    norm_code <= 1'b0;
    norm_addr <= 11'h005;
    repeat (2) @(posedge clk);
    chk_word({24'h00_0000, norm_rdata}, 32'h0000_00A5);
    norm_code <= 1'b1;
    norm_addr <= 11'h7FF;
    repeat (2) @(posedge clk);
    chk_word({24'h00_0000, norm_rdata}, 32'h0000_003C);
  endtask

  task automatic t_power();
    logic [31:0] r;
    @(posedge clk);
    power_good <= 1'b0;
    repeat (6) @(posedge clk);
    power_good <= 1'b1;
    repeat (20) @(posedge clk);
    chk_bit(prog_mode, 1'b0);
    t_enter();
    send(32'h2100_0500, r);
    ahb(1'b0, sep_pkg::REG_STATUS, 32'h0000_0000, rd);
    chk_bit(rd[2], 1'b0);
    send(32'h2100_0500, r);
    chk_word(r, 32'h0000_05A5);
  endtask

  task automatic summarize();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    #300000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end

  // main sequence
  initial begin
    errors     = 0;
    checked    = 0;
    reset_n    = 1'b0;
    power_good = 1'b1;
    norm_code  = 1'b0;
    norm_addr  = 11'h000;
    hsel       = 1'b0;
    haddr      = 32'h0000_0000;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0000_0000;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_enter();
    t_words();
    t_normal();
    t_power();
    summarize();
  end
endmodule
`default_nettype wire
